// [rtl/vbs_top.sv]
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
// Overview of operation
// - the three monitored phase magnitudes feed every supervision stage here.
// - trip_inhibit suppresses all frequency based tripping while any stage blocks.
// - each phase is compared continuously against minimum and maximum thresholds.
// - any phase below minimum is undervoltage; any above maximum is overvoltage.
// - an active undervoltage or overvoltage stage inhibits all tripping stages.
// - activation and reset delays: condition persists or stays absent before changing.
// - separate enables; thresholds zero to 1.4 Vn in 0.05 Vn steps.
// - voltage stage delays zero to 60 s in 50 ms steps.
// - unbalance stage uses largest phase deviation from the three-phase mean.
// - mean is sum over three; ratio is max deviation over mean.
// - while ratio exceeds its setting the unbalance stage inhibits tripping.
// - unbalance block holds for a programmable reset delay after ratio drops.
// - unbalance enable, ratio 0.05 to 1 step 0.05, delay 0-60 s.
module vbs_top
	import vbs_pkg::*;
#(
	parameter logic [VOLT_W-1:0] VN_CODE     = VN_CODE_DFLT,
	parameter int                TICK_CYCLES = TICK_CYCLES_DFLT
)(
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	input  wire vbs_volt_s         meas_volt,
	input  wire logic              meas_valid,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [DATA_W-1:0]      reg_rdata,
	output vbs_block_s             stage_block,
	output logic                   trip_inhibit,
	output logic                   irq
);
	localparam int TICK_W = $clog2(TICK_CYCLES);
	localparam int THR_W  = VOLT_W + CODE_W;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [THR_W-1:0]  VN_STEP   = THR_W'(VN_CODE / STEPS_PER_VN);

	// refused at elaboration, not at run time, so a bad setting never reaches logic
	if (TICK_CYCLES < 2) begin : g_bad_tick
		$error("TICK_CYCLES must be at least 2");
	end
	if (VN_CODE % STEPS_PER_VN != 0 || VN_CODE == '0) begin : g_bad_vn
		$error("VN_CODE must be a nonzero multiple of the step count");
	end
	if (32'(VN_CODE) * 32'(THR_CODE_MAX) / STEPS_PER_VN > (1 << VOLT_W) - 1) begin : g_big_vn
		$error("VN_CODE too large for the top threshold");
	end


	// =====================================================================
	// 50 ms tick divider
	logic [TICK_W-1:0] div_reg;
	logic [TICK_W-1:0] div_next;
	logic              tick_reg;
	logic              tick_next;

	always_comb begin
		if (div_reg == TICK_LAST) begin
			div_next  = '0;
			tick_next = 1'b1;
		end else begin
			div_next  = div_reg + 1'b1;
			tick_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			tick_reg <= tick_next;
		end
	end

	// =====================================================================
	// settings registers
	logic [CTRL_W-1:0] ctrl_reg;
	logic [CTRL_W-1:0] ctrl_next;
	logic [CODE_W-1:0] uv_thr_reg;
	logic [CODE_W-1:0] uv_thr_next;
	logic [CODE_W-1:0] ov_thr_reg;
	logic [CODE_W-1:0] ov_thr_next;
	logic [CODE_W-1:0] ratio_reg;
	logic [CODE_W-1:0] ratio_next;
	logic [DLY_W-1:0]  dly_reg  [5];
	logic [DLY_W-1:0]  dly_next [5];
	logic [IRQ_W-1:0]  irq_mask_reg;
	logic [IRQ_W-1:0]  irq_mask_next;

	// out-of-range writes are clamped so the stages never see an illegal code
	function automatic logic [DATA_W-1:0] clamp(input logic [DATA_W-1:0] v,
		input logic [DATA_W-1:0] lo, input logic [DATA_W-1:0] hi);
		if (v < lo) begin
			return lo;
		end
		return (v > hi) ? hi : v;
	endfunction

	always_comb begin
		ctrl_next     = ctrl_reg;
		uv_thr_next   = uv_thr_reg;
		ov_thr_next   = ov_thr_reg;
		ratio_next    = ratio_reg;
		dly_next      = dly_reg;
		irq_mask_next = irq_mask_reg;
		if (reg_wr) begin
			case (reg_addr)
				OFS_CTRL: begin
					ctrl_next = reg_wdata[CTRL_W-1:0];
				end
				OFS_UV_THR: begin
					uv_thr_next = CODE_W'(clamp(reg_wdata, '0, DATA_W'(THR_CODE_MAX)));
				end
				OFS_OV_THR: begin
					ov_thr_next = CODE_W'(clamp(reg_wdata, '0, DATA_W'(THR_CODE_MAX)));
				end
				OFS_UNB_RATIO: begin
					ratio_next = CODE_W'(clamp(reg_wdata, DATA_W'(RATIO_CODE_MIN),
						DATA_W'(RATIO_CODE_MAX)));
				end
				OFS_UV_ACT: begin
					dly_next[0] = DLY_W'(clamp(reg_wdata, '0, DATA_W'(DLY_CODE_MAX)));
				end
				OFS_UV_RST: begin
					dly_next[1] = DLY_W'(clamp(reg_wdata, '0, DATA_W'(DLY_CODE_MAX)));
				end
				OFS_OV_ACT: begin
					dly_next[2] = DLY_W'(clamp(reg_wdata, '0, DATA_W'(DLY_CODE_MAX)));
				end
				OFS_OV_RST: begin
					dly_next[3] = DLY_W'(clamp(reg_wdata, '0, DATA_W'(DLY_CODE_MAX)));
				end
				OFS_UNB_RST: begin
					dly_next[4] = DLY_W'(clamp(reg_wdata, '0, DATA_W'(DLY_CODE_MAX)));
				end
				OFS_IRQ_MASK: begin
					irq_mask_next = reg_wdata[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg     <= RST_CTRL;
			uv_thr_reg   <= RST_UV_THR;
			ov_thr_reg   <= RST_OV_THR;
			ratio_reg    <= RST_UNB_RATIO;
			dly_reg      <= '{default: RST_DLY};
			irq_mask_reg <= RST_IRQ;
		end else begin
			ctrl_reg     <= ctrl_next;
			uv_thr_reg   <= uv_thr_next;
			ov_thr_reg   <= ov_thr_next;
			ratio_reg    <= ratio_next;
			dly_reg      <= dly_next;
			irq_mask_reg <= irq_mask_next;
		end
	end

	// =====================================================================
	// measurement capture and threshold compare
	vbs_volt_s         volt_reg;
	vbs_volt_s         volt_next;
	logic [VOLT_W-1:0] ph [3];
	logic [THR_W-1:0]  uv_thr;
	logic [THR_W-1:0]  ov_thr;
	logic              uv_cond;
	logic              ov_cond;
	logic              unb_cond;

	always_comb begin
		volt_next = volt_reg;
		if (meas_valid) begin
			volt_next = meas_volt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			volt_reg <= '0;
		end else begin
			volt_reg <= volt_next;
		end
	end

	assign ph[0]  = volt_reg.a;
	assign ph[1]  = volt_reg.b;
	assign ph[2]  = volt_reg.c;
	assign uv_thr = THR_W'(uv_thr_reg) * VN_STEP;
	assign ov_thr = THR_W'(ov_thr_reg) * VN_STEP;

	// compare runs every cycle, so a new setting acts on the held sample
	always_comb begin
		uv_cond = 1'b0;
		ov_cond = 1'b0;
		for (int i = 0; i < 3; i++) begin
			uv_cond = uv_cond | (THR_W'(ph[i]) < uv_thr);
			ov_cond = ov_cond | (THR_W'(ph[i]) > ov_thr);
		end
	end

	vbs_unbalance u_unbalance (
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.volt       (meas_volt),
		.valid      (meas_valid),
		.ratio_code (ratio_reg),
		.over       (unb_cond)
	);

	// =====================================================================
	// blocking stages
	vbs_block_s blk;

	vbs_delay_timer u_uv_timer (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.enable  (ctrl_reg[CTRL_UV_EN]),
		.tick    (tick_reg),
		.cond    (uv_cond),
		.act_dly (dly_reg[0]),
		.rst_dly (dly_reg[1]),
		.blocked (blk.uv)
	);

	vbs_delay_timer u_ov_timer (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.enable  (ctrl_reg[CTRL_OV_EN]),
		.tick    (tick_reg),
		.cond    (ov_cond),
		.act_dly (dly_reg[2]),
		.rst_dly (dly_reg[3]),
		.blocked (blk.ov)
	);

	// no activation delay: the unbalance stage blocks as soon as the ratio is high
	vbs_delay_timer u_unb_timer (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.enable  (ctrl_reg[CTRL_UNB_EN]),
		.tick    (tick_reg),
		.cond    (unb_cond),
		.act_dly ('0),
		.rst_dly (dly_reg[4]),
		.blocked (blk.unb)
	);

	assign stage_block = blk;

	// =====================================================================
	// inhibit, interrupt and read-back
	logic              inhibit_reg;
	logic              inhibit_next;
	vbs_block_s        blk_prev_reg;
	logic [IRQ_W-1:0]  irq_status_reg;
	logic [IRQ_W-1:0]  irq_status_next;
	logic [IRQ_W-1:0]  irq_event;
	logic [IRQ_W-1:0]  irq_clear;
	logic              irq_reg;
	logic              irq_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [DATA_W-1:0] status_word;

	assign inhibit_next = blk.uv | blk.ov | blk.unb;

	always_comb begin
		irq_event = {inhibit_reg & ~inhibit_next, blk & ~blk_prev_reg};
		irq_clear = '0;
		if (reg_wr && reg_addr == OFS_IRQ_STATUS) begin
			irq_clear = reg_wdata[IRQ_W-1:0];
		end
		// a new event beats a clear in the same cycle
		irq_status_next = (irq_status_reg & ~irq_clear) | irq_event;
		irq_next        = |(irq_status_reg & irq_mask_reg);
	end

	always_comb begin
		status_word = '0;
		status_word[ST_UV_COND]                 = uv_cond;
		status_word[ST_OV_COND]                 = ov_cond;
		status_word[ST_UNB_COND]                = unb_cond;
		status_word[ST_BLK_LSB +: $bits(blk)]   = blk;
		status_word[ST_INHIBIT]                 = inhibit_reg;
		rdata_next = '0;
		if (reg_rd) begin
			case (reg_addr)
				OFS_CTRL:       rdata_next = DATA_W'(ctrl_reg);
				OFS_UV_THR:     rdata_next = DATA_W'(uv_thr_reg);
				OFS_OV_THR:     rdata_next = DATA_W'(ov_thr_reg);
				OFS_UNB_RATIO:  rdata_next = DATA_W'(ratio_reg);
				OFS_UV_ACT:     rdata_next = DATA_W'(dly_reg[0]);
				OFS_UV_RST:     rdata_next = DATA_W'(dly_reg[1]);
				OFS_OV_ACT:     rdata_next = DATA_W'(dly_reg[2]);
				OFS_OV_RST:     rdata_next = DATA_W'(dly_reg[3]);
				OFS_UNB_RST:    rdata_next = DATA_W'(dly_reg[4]);
				OFS_STATUS:     rdata_next = status_word;
				OFS_IRQ_STATUS: rdata_next = DATA_W'(irq_status_reg);
				OFS_IRQ_MASK:   rdata_next = DATA_W'(irq_mask_reg);
				default:        rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			inhibit_reg    <= 1'b0;
			blk_prev_reg   <= '0;
			irq_status_reg <= RST_IRQ;
			irq_reg        <= 1'b0;
			rdata_reg      <= '0;
		end else begin
			inhibit_reg    <= inhibit_next;
			blk_prev_reg   <= blk;
			irq_status_reg <= irq_status_next;
			irq_reg        <= irq_next;
			rdata_reg      <= rdata_next;
		end
	end

	assign trip_inhibit = inhibit_reg;
	assign irq          = irq_reg;
	assign reg_rdata    = rdata_reg;

	// =====================================================================
	// checks
	chk_inhibit_or: assert property (@(posedge ref_clk) disable iff (!nrst)
		inhibit_reg == $past(blk.uv | blk.ov | blk.unb))
		else $error("inhibit is not the OR of the stages");
	chk_volt_inhibit: assert property (@(posedge ref_clk) disable iff (!nrst)
		blk.uv || blk.ov |=> trip_inhibit)
		else $error("voltage block did not inhibit tripping");
	chk_unb_inhibit: assert property (@(posedge ref_clk) disable iff (!nrst)
		ctrl_reg[CTRL_UNB_EN] && unb_cond && !blk.unb |=> ##1 trip_inhibit)
		else $error("unbalance did not inhibit within two cycles");
	chk_uv_disabled: assert property (@(posedge ref_clk) disable iff (!nrst)
		!ctrl_reg[CTRL_UV_EN] |=> !blk.uv)
		else $error("disabled undervoltage stage blocks");
	chk_tick_single: assert property (@(posedge ref_clk) disable iff (!nrst)
		tick_reg |=> !tick_reg)
		else $error("tick longer than one cycle");
	chk_meas_latch: assert property (@(posedge ref_clk) disable iff (!nrst)
		meas_valid |=> volt_reg == $past(meas_volt))
		else $error("measurement not captured");
	chk_sticky_set: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(blk.uv) |=> irq_status_reg[0])
		else $error("undervoltage event not latched");
	chk_irq_level: assert property (@(posedge ref_clk) disable iff (!nrst)
		irq_reg == $past(|(irq_status_reg & irq_mask_reg)))
		else $error("interrupt output does not follow masked status");
	chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
		!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside the read answer cycle");
endmodule

// [inc/vbs_pkg.sv]
package vbs_pkg;
	// =====================================================================
	// data widths and scaling
	localparam int VOLT_W       = 16;
	localparam int STEPS_PER_VN = 20;
	localparam int CODE_W       = 5;
	localparam int DLY_W        = 11;
	localparam int ADDR_W       = 8;
	localparam int DATA_W       = 32;
	localparam logic [VOLT_W-1:0] VN_CODE_DFLT = 16'h0fa0;
	localparam logic [CODE_W-1:0] THR_CODE_MAX   = 5'h1c; // 1.4 Vn
	localparam logic [CODE_W-1:0] RATIO_CODE_MIN = 5'h01; // 0.05
	localparam logic [CODE_W-1:0] RATIO_CODE_MAX = 5'h14; // 1.00

	// =====================================================================
	// timing
	localparam int CLK_FREQ_HZ      = 100_000_000;
	localparam int TICK_PERIOD_MS   = 50;
	localparam int DLY_MAX_MS       = 60_000;
	localparam int TICK_CYCLES_DFLT = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
	localparam logic [DLY_W-1:0] DLY_CODE_MAX = DLY_W'(DLY_MAX_MS / TICK_PERIOD_MS);

	// =====================================================================
	// register map
	localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_UV_THR     = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_OV_THR     = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_UNB_RATIO  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_UV_ACT     = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_UV_RST     = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_OV_ACT     = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_OV_RST     = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_UNB_RST    = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 8'h2c;

	localparam int CTRL_UV_EN  = 0;
	localparam int CTRL_OV_EN  = 1;
	localparam int CTRL_UNB_EN = 2;
	localparam int CTRL_W      = 3;

	localparam int ST_UV_COND  = 0;
	localparam int ST_OV_COND  = 1;
	localparam int ST_UNB_COND = 2;
	localparam int ST_BLK_LSB  = 4;
	localparam int ST_INHIBIT  = 8;

	localparam int IRQ_RELEASE = 3;
	localparam int IRQ_W       = 4;

	localparam logic [CTRL_W-1:0] RST_CTRL      = 3'h0;
	localparam logic [CODE_W-1:0] RST_UV_THR    = 5'h00;
	localparam logic [CODE_W-1:0] RST_OV_THR    = 5'h1c;
	localparam logic [CODE_W-1:0] RST_UNB_RATIO = 5'h14;
	localparam logic [DLY_W-1:0]  RST_DLY       = 11'h000;
	localparam logic [IRQ_W-1:0]  RST_IRQ       = 4'h0;

	// =====================================================================
	// carriers
	typedef struct packed {
		logic [VOLT_W-1:0] a;
		logic [VOLT_W-1:0] b;
		logic [VOLT_W-1:0] c;
	} vbs_volt_s;

	typedef struct packed {
		logic unb;
		logic ov;
		logic uv;
	} vbs_block_s;
endpackage

// [rtl/vbs_delay_timer.sv]
`timescale 1ns/100ps
module vbs_delay_timer
	import vbs_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	input  wire logic             enable,
	input  wire logic             tick,
	input  wire logic             cond,
	input  wire logic [DLY_W-1:0] act_dly,
	input  wire logic [DLY_W-1:0] rst_dly,
	output logic                  blocked
);
	// =====================================================================
	// state
	logic             blocked_reg;
	logic             blocked_next;
	logic [DLY_W-1:0] cnt_reg;
	logic [DLY_W-1:0] cnt_next;

	// counter never passes the delay it is compared with, so it cannot wrap
	always_comb begin
		blocked_next = blocked_reg;
		cnt_next     = cnt_reg;
		if (!enable) begin
			blocked_next = 1'b0;
			cnt_next     = '0;
		end else if (!blocked_reg) begin
			if (!cond) begin
				cnt_next = '0;
			end else if (cnt_reg >= act_dly) begin
				blocked_next = 1'b1;
				cnt_next     = '0;
			end else if (tick) begin
				cnt_next = cnt_reg + 1'b1;
			end
		end else begin
			if (cond) begin
				cnt_next = '0;
			end else if (cnt_reg >= rst_dly) begin
				blocked_next = 1'b0;
				cnt_next     = '0;
			end else if (tick) begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			blocked_reg <= 1'b0;
			cnt_reg     <= '0;
		end else begin
			blocked_reg <= blocked_next;
			cnt_reg     <= cnt_next;
		end
	end

	assign blocked = blocked_reg;

	// =====================================================================
	// checks
	chk_disabled_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		!enable |=> !blocked_reg && cnt_reg == '0)
		else $error("disabled stage not cleared");
	chk_assert_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(blocked_reg) |-> $past(cond) && $past(enable) && $past(cnt_reg) >= $past(act_dly))
		else $error("block asserted without persisting condition");
	chk_release_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
		$fell(blocked_reg) && $past(enable) |-> !$past(cond) && $past(cnt_reg) >= $past(rst_dly))
		else $error("block released too early");
	chk_zero_act: assert property (@(posedge ref_clk) disable iff (!nrst)
		enable && !blocked_reg && cond && act_dly == '0 |=> blocked_reg)
		else $error("zero activation delay not immediate");
endmodule

// [rtl/vbs_unbalance.sv]
`timescale 1ns/100ps
module vbs_unbalance
	import vbs_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	input  wire vbs_volt_s         volt,
	input  wire logic              valid,
	input  wire logic [CODE_W-1:0] ratio_code,
	output logic                   over
);
	localparam int S_W = VOLT_W + 2;
	localparam int P_W = S_W + CODE_W;
	localparam logic [P_W-1:0] STEPS = P_W'(STEPS_PER_VN);

	// =====================================================================
	// ratio test without a divider: max|3v - s| * 20 > code * s
	logic [S_W-1:0] sum;
	logic [S_W-1:0] dev [3];
	logic [S_W-1:0] max_dev;
	logic [S_W-1:0] tri_v;
	logic [VOLT_W-1:0] ph [3];
	logic [P_W-1:0] lhs;
	logic [P_W-1:0] rhs;
	logic           over_reg;
	logic           over_next;

	assign ph[0] = volt.a;
	assign ph[1] = volt.b;
	assign ph[2] = volt.c;
	assign sum   = S_W'(ph[0]) + S_W'(ph[1]) + S_W'(ph[2]);

	always_comb begin
		tri_v   = '0;
		max_dev = '0;
		for (int i = 0; i < 3; i++) begin
			tri_v  = S_W'(ph[i]) * S_W'(3);
			dev[i] = (tri_v > sum) ? tri_v - sum : sum - tri_v;
			if (dev[i] > max_dev) begin
				max_dev = dev[i];
			end
		end
	end

	assign lhs = P_W'(max_dev) * STEPS;
	assign rhs = P_W'(ratio_code) * P_W'(sum);

	// zero mean gives lhs = 0, so no unbalance is flagged
	always_comb begin
		over_next = over_reg;
		if (valid) begin
			over_next = lhs > rhs;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			over_reg <= 1'b0;
		end else begin
			over_reg <= over_next;
		end
	end

	assign over = over_reg;

	chk_zero_mean: assert property (@(posedge ref_clk) disable iff (!nrst)
		valid && sum == '0 |=> !over_reg)
		else $error("unbalance flagged on zero mean");
endmodule

// [test/vbs_meas_src.sv]
`timescale 1ns/100ps
module vbs_meas_src
	import vbs_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire logic      nrst,
	input  wire logic      go,
	input  wire vbs_volt_s volt_in,
	output vbs_volt_s      meas_volt,
	output logic           meas_valid
);
	// =====================================================================
	// upstream magnitude source
	// data outside the valid cycle toggles so stale values are never trusted
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			meas_volt  <= '0;
			meas_valid <= 1'b0;
		end else begin
			meas_valid <= go;
			if (go) begin
				meas_volt <= volt_in;
			end else begin
				meas_volt <= ~meas_volt;
			end
		end
	end
endmodule

// [test/testbench.sv]
`timescale 1ns/100ps
module testbench
	import vbs_pkg::*;
;
	localparam logic [15:0] NOM = 16'h0fa0;
	localparam logic [15:0] LOW = 16'h03e8;
	logic              ref_clk;
	logic              nrst;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [DATA_W-1:0] reg_rdata;
	vbs_block_s        stage_block;
	logic              trip_inhibit;
	logic              irq;
	vbs_volt_s         meas_volt;
	logic              meas_valid;
	vbs_volt_s         src_volt;
	logic              src_go;
	logic [DATA_W-1:0] rv;
	int                bad_count = 0;
	int                check_count = 0;
	int                cyc = 0;

	// =====================================================================
	// design and source model
	// short tick keeps delay scenarios to a few dozen cycles
	vbs_top #(.TICK_CYCLES(4)) dut (
		.ref_clk      (ref_clk),
		.nrst         (nrst),
		.meas_volt    (meas_volt),
		.meas_valid   (meas_valid),
		.reg_addr     (reg_addr),
		.reg_wdata    (reg_wdata),
		.reg_wr       (reg_wr),
		.reg_rd       (reg_rd),
		.reg_rdata    (reg_rdata),
		.stage_block  (stage_block),
		.trip_inhibit (trip_inhibit),
		.irq          (irq)
	);
	vbs_meas_src src (
		.ref_clk    (ref_clk),
		.nrst       (nrst),
		.go         (src_go),
		.volt_in    (src_volt),
		.meas_volt  (meas_volt),
		.meas_valid (meas_valid)
	);

	// =====================================================================
	// helpers
	task automatic close_out();
		if (bad_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [DATA_W-1:0] seen,
			input logic [DATA_W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic apply(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		@(posedge ref_clk);
		src_go   <= 1'b1;
		src_volt <= {a, b, c};
		@(posedge ref_clk);
		src_go <= 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	function automatic logic [DATA_W-1:0] blk();
		return {29'h0, stage_block};
	endfunction

	// =====================================================================
	// scenarios
	task automatic t_regs();
		rd(OFS_CTRL, rv);
		chk("ctrl", rv, 32'h0);
		@(posedge ref_clk);
		#1;
		chk("rdata idle", reg_rdata, 32'h0);
		rd(OFS_OV_THR, rv);
		chk("ov thr", rv, 32'h1c);
		rd(OFS_UNB_RATIO, rv);
		chk("ratio", rv, 32'h14);
		rd(8'h30, rv);
		chk("unmapped", rv, 32'h0);
		wr(OFS_OV_THR, 32'h1f);
		rd(OFS_OV_THR, rv);
		chk("ov thr clamp", rv, 32'h1c);
		wr(OFS_UNB_RST, 32'hffff);
		rd(OFS_UNB_RST, rv);
		chk("delay clamp", rv, 32'h4b0);
		wr(OFS_UNB_RATIO, 32'h0);
		rd(OFS_UNB_RATIO, rv);
		chk("ratio clamp", rv, 32'h1);
	endtask
	task automatic t_uv();
		wr(OFS_UV_THR, 32'ha);
		wr(OFS_IRQ_MASK, 32'h1);
		apply(LOW, NOM, NOM);
		idle(6);
		chk("disabled block", blk(), 32'h0);
		chk("disabled inhibit", {31'h0, trip_inhibit}, 32'h0);
		wr(OFS_CTRL, 32'h1);
		idle(4);
		chk("uv block", blk(), 32'h1);
		chk("uv inhibit", {31'h0, trip_inhibit}, 32'h1);
		chk("uv irq", {31'h0, irq}, 32'h1);
		rd(OFS_STATUS, rv);
		chk("uv status", rv & 32'h133, 32'h111);
		wr(OFS_IRQ_STATUS, 32'h1);
		idle(3);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		apply(NOM, NOM, NOM);
		idle(6);
		chk("uv release", blk(), 32'h0);
		chk("inhibit release", {31'h0, trip_inhibit}, 32'h0);
		rd(OFS_IRQ_STATUS, rv);
		chk("release event", rv & 32'h8, 32'h8);
		chk("masked irq", {31'h0, irq}, 32'h0);
		wr(OFS_IRQ_STATUS, 32'hf);
		wr(OFS_CTRL, 32'h0);
	endtask
	task automatic t_ov();
		wr(OFS_OV_ACT, 32'h3);
		wr(OFS_CTRL, 32'h2);
		apply(NOM, 16'h15e0, NOM);
		idle(6);
		chk("ov at thr", blk(), 32'h0);
		apply(NOM, 16'h1770, NOM);
		idle(6);
		chk("ov early", blk(), 32'h0);
		idle(18);
		chk("ov late", blk(), 32'h2);
		chk("ov inhibit", {31'h0, trip_inhibit}, 32'h1);
		wr(OFS_OV_RST, 32'h2);
		apply(NOM, NOM, NOM);
		idle(4);
		chk("ov hold", blk(), 32'h2);
		idle(20);
		chk("ov release", blk(), 32'h0);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_OV_ACT, 32'h0);
		wr(OFS_OV_RST, 32'h0);
	endtask
	task automatic t_unb();
		wr(OFS_UNB_RATIO, 32'h2);
		wr(OFS_UNB_RST, 32'h2);
		wr(OFS_CTRL, 32'h4);
		apply(16'h0000, 16'h0000, 16'h0000);
		idle(6);
		chk("unb zero mean", blk(), 32'h0);
		apply(NOM, NOM, 16'h0dac);
		idle(6);
		chk("unb below", blk(), 32'h0);
		apply(NOM, NOM, 16'h0d48);
		idle(6);
		chk("unb above", blk(), 32'h4);
		chk("unb inhibit", {31'h0, trip_inhibit}, 32'h1);
		apply(NOM, NOM, NOM);
		idle(4);
		chk("unb hold", blk(), 32'h4);
		idle(20);
		chk("unb release", blk(), 32'h0);
		rd(OFS_IRQ_STATUS, rv);
		chk("stage events", rv, 32'he);
		chk("masked irq unb", {31'h0, irq}, 32'h0);
		wr(OFS_CTRL, 32'h0);
	endtask

	// =====================================================================
	// clock, watchdog, sequence
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			close_out();
		end
	end
	initial begin
		nrst      = 1'b0;
		reg_addr  = '0;
		reg_wdata = '0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		src_go    = 1'b0;
		src_volt  = {NOM, NOM, NOM};
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		t_regs();
		t_uv();
		t_ov();
		t_unb();
		close_out();
	end
endmodule
